// ===== src/sarseq_params.svh
// Constants of the converter sequencer: widths, timing, byte layout.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef SARSEQ_PARAMS_SVH
`define SARSEQ_PARAMS_SVH
`define SARSEQ_CLK_PERIOD_PS   5000
`define SARSEQ_TCONV_NS        4700
`define SARSEQ_TCONV_CYC       ((`SARSEQ_TCONV_NS * 1000) / `SARSEQ_CLK_PERIOD_PS)
`define SARSEQ_RES_BITS        14
`define SARSEQ_LANE_BITS       8
`define SARSEQ_HI_BITS         6
`define SARSEQ_FIFO_DEPTH      16
`define SARSEQ_LOAD_SLOT       15
`define SARSEQ_PIN_LAT         4
`endif

// ===== src/sarseq_pkg.sv
// Types shared by the converter sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sarseq_pkg;
    typedef enum logic [2:0] {
        SQ_IDLE,
        SQ_ACQ,
        SQ_CONV,
        SQ_DONE,
        SQ_READ
    } sarseq_state_t;
    typedef enum logic [1:0] {
        PW_OFF,
        PW_STANDBY,
        PW_ON
    } sarseq_power_t;
endpackage

// ===== src/sarseq_stream_if.sv
// Valid/ready word stream between the sequencer's own modules.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface sarseq_stream_if #(parameter int W = 14);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== src/sarseq_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sarseq_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Filling and draining sides
    sarseq_stream_if.snk inS,
    sarseq_stream_if.src outS
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("sarseq_fifo: DEPTH must be a power of two >= 2");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      wrPtr_d;
    logic [AW:0]      rdPtr_q;
    logic [AW:0]      rdPtr_d;
    logic             full;
    logic             empty;
    logic             doWr;
    logic             doRd;
    // Full and empty from pointer wrap bits
    always_comb begin
        empty   = (wrPtr_q == rdPtr_q);
        full    = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
        doWr    = inS.valid && !full;
        doRd    = outS.ready && !empty;
        wrPtr_d = wrPtr_q + (AW+1)'(doWr);
        rdPtr_d = rdPtr_q + (AW+1)'(doRd);
        inS.ready  = !full;
        outS.valid = !empty;
        outS.data  = mem[rdPtr_q[AW-1:0]];
    end
    // Pointer registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
    end
    // Storage, no reset needed
    always_ff @(posedge clock) begin
        if (doWr) begin
            mem[wrPtr_q[AW-1:0]] <= inS.data;
        end
    end
endmodule
`default_nettype wire

// ===== src/sarseq_top.sv
// Control sequencer of a 14-bit SAR converter with byte-wide readout.
// Assumes pins arrive asynchronously; the SAR result is supplied as a word.
`timescale 1ns/1ps
`default_nettype none
`include "sarseq_params.svh"
module sarseq_top #(
    parameter int RES_BITS  = `SARSEQ_RES_BITS,
    parameter int CONV_CYC  = `SARSEQ_TCONV_CYC,
    parameter int FIFO_DEPTH = `SARSEQ_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                           clock,
    input  wire logic                           rst,
    // Host pins
    input  wire logic                           convStrobeN,
    input  wire logic                           readSel,
    input  wire logic                           byteSelect,
    // Result word from the SAR array
    input  wire logic [`SARSEQ_RES_BITS-1:0]    sarResult,
    // Host-facing outputs
    output var  logic                           eocN,
    output var  logic [`SARSEQ_LANE_BITS-1:0]   dataLaneOut,
    output var  logic [`SARSEQ_LANE_BITS-1:0]   dataLaneOe,
    // Analog front-end controls
    output var  logic                           trackHold,
    output var  logic                           refPowered,
    output var  logic                           corePowered
);
    initial begin
        if (RES_BITS != `SARSEQ_RES_BITS || CONV_CYC <= `SARSEQ_PIN_LAT || CONV_CYC > 4095) begin
            $error("sarseq_top: unsupported parameter values");
        end
    end
    localparam int CW = $clog2(CONV_CYC + 1);
    // Three-stage pin synchronisers
    logic [2:0] csSync_q;
    logic [2:0] rcSync_q;
    logic [2:0] hbSync_q;
    logic       csLvl_q;
    logic       rcLvl_q;
    logic       hbLvl_q;
    logic       csFall;
    logic       csRise;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            csSync_q <= 3'h7;
            rcSync_q <= 3'h0;
            hbSync_q <= 3'h0;
            csLvl_q  <= 1'h1;
            rcLvl_q  <= 1'h0;
            hbLvl_q  <= 1'h0;
        end else begin
            csSync_q <= {csSync_q[1:0], convStrobeN};
            rcSync_q <= {rcSync_q[1:0], readSel};
            hbSync_q <= {hbSync_q[1:0], byteSelect};
            if (csSync_q[1] == csSync_q[2]) csLvl_q <= csSync_q[2];
            if (rcSync_q[1] == rcSync_q[2]) rcLvl_q <= rcSync_q[2];
            if (hbSync_q[1] == hbSync_q[2]) hbLvl_q <= hbSync_q[2];
        end
    end
    // Strobe edges on the agreed level
    always_comb begin
        csFall = csLvl_q && (csSync_q[1] == csSync_q[2]) && !csSync_q[2];
        csRise = !csLvl_q && (csSync_q[1] == csSync_q[2]) && csSync_q[2];
    end
    // Result buffer between converter and bus
    sarseq_stream_if #(.W(RES_BITS)) wrS ();
    sarseq_stream_if #(.W(RES_BITS)) rdS ();
    sarseq_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) uFifo (
        .clock (clock),
        .rst   (rst),
        .inS   (wrS),
        .outS  (rdS)
    );
    sarseq_pkg::sarseq_state_t state_q;
    sarseq_pkg::sarseq_state_t state_d;
    sarseq_pkg::sarseq_power_t power_q;
    sarseq_pkg::sarseq_power_t power_d;
    logic [CW-1:0]             cnt_q;
    logic [CW-1:0]             cnt_d;
    logic                      shutSel_q;
    logic                      shutSel_d;
    logic [RES_BITS-1:0]       word_q;
    logic [RES_BITS-1:0]       word_d;
    logic                      eocN_d;
    logic                      drive_d;
    logic [7:0]                lanes_d;
    // Sequencer next-state logic
    always_comb begin
        state_d   = state_q;
        power_d   = power_q;
        cnt_d     = cnt_q;
        shutSel_d = shutSel_q;
        word_d    = word_q;
        eocN_d    = eocN;
        drive_d   = dataLaneOe[0];
        wrS.valid = 1'b0;
        wrS.data  = sarResult;
        rdS.ready = 1'b0;
        unique case (state_q)
            sarseq_pkg::SQ_IDLE, sarseq_pkg::SQ_DONE: begin
                if (csFall && !rcLvl_q) begin
                    state_d = sarseq_pkg::SQ_ACQ;
                    power_d = sarseq_pkg::PW_ON;
                    eocN_d  = 1'b1;
                    drive_d = 1'b0;
                    // An unread result is dropped so a later readout shows the newest one
                    rdS.ready = (state_q == sarseq_pkg::SQ_DONE);
                end else if (state_q == sarseq_pkg::SQ_DONE && csFall && rdS.valid) begin
                    state_d   = sarseq_pkg::SQ_READ;
                    rdS.ready = 1'b1;
                    word_d    = rdS.data;
                    drive_d   = 1'b1;
                end
            end
            sarseq_pkg::SQ_ACQ: begin
                if (csFall) begin
                    state_d   = sarseq_pkg::SQ_CONV;
                    shutSel_d = rcLvl_q;
                    cnt_d     = '0;
                end
            end
            sarseq_pkg::SQ_CONV: begin
                cnt_d = cnt_q + CW'(1);
                // Budget includes the pin synchroniser delay so the limit holds from the pin
                if (cnt_q == CW'(CONV_CYC - 1 - `SARSEQ_PIN_LAT) && wrS.ready) begin
                    wrS.valid = 1'b1;
                    state_d   = sarseq_pkg::SQ_DONE;
                    eocN_d    = 1'b0;
                    power_d   = shutSel_q ? sarseq_pkg::PW_OFF : sarseq_pkg::PW_STANDBY;
                end
            end
            sarseq_pkg::SQ_READ: begin
                if (csRise) begin
                    state_d = sarseq_pkg::SQ_IDLE;
                    drive_d = 1'b0;
                end
            end
            default: state_d = sarseq_pkg::SQ_IDLE;
        endcase
        // Byte mux; upper two lanes of high byte forced low
        if (hbLvl_q) begin
            lanes_d = {2'h0, word_d[RES_BITS-1:`SARSEQ_LANE_BITS]};
        end else begin
            lanes_d = word_d[`SARSEQ_LANE_BITS-1:0];
        end
    end
    // Sequencer registers and output flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q     <= sarseq_pkg::SQ_IDLE;
            power_q     <= sarseq_pkg::PW_OFF;
            cnt_q       <= '0;
            shutSel_q   <= 1'b0;
            word_q      <= '0;
            eocN        <= 1'b1;
            dataLaneOut <= 8'h00;
            dataLaneOe  <= 8'h00;
            trackHold   <= 1'b0;
            refPowered  <= 1'b0;
            corePowered <= 1'b0;
        end else begin
            state_q     <= state_d;
            power_q     <= power_d;
            cnt_q       <= cnt_d;
            shutSel_q   <= shutSel_d;
            word_q      <= word_d;
            eocN        <= eocN_d;
            dataLaneOut <= lanes_d;
            dataLaneOe  <= {8{drive_d}};
            trackHold   <= (state_d == sarseq_pkg::SQ_ACQ);
            refPowered  <= (power_d != sarseq_pkg::PW_OFF);
            corePowered <= (power_d == sarseq_pkg::PW_ON);
        end
    end
    // Checks
    sequence s_convStart;
        state_q == sarseq_pkg::SQ_ACQ && csFall;
    endsequence
    property p_eocTime;
        @(posedge clock) disable iff (rst)
        s_convStart |-> ##[1:940] !eocN;
    endproperty
    a_eocTime: assert property (p_eocTime) else $error("EOC late");
    property p_ignore;
        @(posedge clock) disable iff (rst)
        (state_q == sarseq_pkg::SQ_IDLE && csFall && rcLvl_q) |=> state_q == sarseq_pkg::SQ_IDLE;
    endproperty
    a_ignore: assert property (p_ignore) else $error("edge not ignored");
    property p_acq;
        @(posedge clock) disable iff (rst)
        (state_q == sarseq_pkg::SQ_IDLE && csFall && !rcLvl_q) |=> ##1 (trackHold && eocN);
    endproperty
    a_acq: assert property (p_acq) else $error("no acquisition");
    property p_shut;
        @(posedge clock) disable iff (rst)
        $fell(eocN) && shutSel_q |-> !refPowered;
    endproperty
    a_shut: assert property (p_shut) else $error("ref not off");
    property p_stby;
        @(posedge clock) disable iff (rst)
        $fell(eocN) && !shutSel_q |-> refPowered && !corePowered;
    endproperty
    a_stby: assert property (p_stby) else $error("ref not standby");
    property p_float;
        @(posedge clock) disable iff (rst)
        (state_q == sarseq_pkg::SQ_CONV) |-> dataLaneOe == 8'h00;
    endproperty
    a_float: assert property (p_float) else $error("lanes driven");
    property p_hiZero;
        @(posedge clock) disable iff (rst)
        $past(hbLvl_q) |-> dataLaneOut[7:6] == 2'h0;
    endproperty
    a_hiZero: assert property (p_hiZero) else $error("high lanes set");
    property p_read;
        @(posedge clock) disable iff (rst)
        (state_q == sarseq_pkg::SQ_DONE && csFall && rcLvl_q) |=> dataLaneOe == 8'hFF;
    endproperty
    a_read: assert property (p_read) else $error("no readout");
endmodule
`default_nettype wire

// ===== test/sarseq_host_model.sv
// Host model: a controller that drives the strobe, select and byte pins.
// Assumes the caller invokes its tasks from one process, in bus order.
`timescale 1ns/1ps
`default_nettype none
module sarseq_host_model #(
    parameter int WAKE_CYC = 100
) (
    // Clock
    input  wire logic clock,
    // Host pins
    output var  logic convStrobeN,
    output var  logic readSel,
    output var  logic byteSelect
);
    logic shutQ;
    logic wakePend;

    // Idle pins: strobe high, device assumed in shutdown after reset
    initial begin
        convStrobeN = 1'b1;
        readSel = 1'b0;
        byteSelect = 1'b0;
        shutQ = 1'b1;
        wakePend = 1'b0;
    end

    // One strobe pulse: select set up first, low 8 cycles, high 8 cycles
    task automatic pulse(input logic rs, input logic bs);
        @(posedge clock);
        readSel <= rs;
        byteSelect <= bs;
        repeat (3) @(posedge clock);
        convStrobeN <= 1'b0;
        repeat (8) @(posedge clock);
        convStrobeN <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    // Acquisition start; a wake from shutdown arms the settle wait
    task automatic acquire();
        pulse(1'b0, byteSelect);
        if (shutQ) begin
            wakePend = 1'b1;
        end
    endtask

    // Conversion start, delayed until the reference has settled
    task automatic convert(input logic shut);
        if (wakePend) begin
            repeat (WAKE_CYC) @(posedge clock);
        end
        wakePend = 1'b0;
        pulse(shut, byteSelect);
        shutQ = shut;
    endtask

    // Readout strobe with the wanted byte selected
    task automatic read(input logic bs);
        pulse(1'b1, bs);
    endtask
endmodule
`default_nettype wire

// ===== test/tb_sar_adc_parallel_sequencer.sv
// Self-checking bench of the converter sequencer, driven by the host model.
// Assumes the sequencer's own assertions guard its internals.
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_parallel_sequencer;
    localparam int CONV = 40;
    logic        clock;
    logic        rst;
    logic [13:0] sarResult;
    logic        convStrobeN;
    logic        readSel;
    logic        byteSelect;
    logic        eocN;
    logic [7:0]  dataLaneOut;
    logic [7:0]  dataLaneOe;
    logic        trackHold;
    logic        refPowered;
    logic        corePowered;
    logic [7:0]  expQ[$];
    logic        oeSeen;
    logic [13:0] r;
    logic        shut;
    logic        bs;
    int          n;
    int          n_mismatch;
    int          checked;

    sarseq_top #(.CONV_CYC(CONV)) dut (
        .clock(clock), .rst(rst), .convStrobeN(convStrobeN), .readSel(readSel),
        .byteSelect(byteSelect), .sarResult(sarResult), .eocN(eocN),
        .dataLaneOut(dataLaneOut), .dataLaneOe(dataLaneOe), .trackHold(trackHold),
        .refPowered(refPowered), .corePowered(corePowered)
    );

    sarseq_host_model #(.WAKE_CYC(100)) host (
        .clock(clock), .convStrobeN(convStrobeN), .readSel(readSel),
        .byteSelect(byteSelect)
    );

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Compare and count
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Report and end the run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Result watcher: each drive-on takes the oldest noted byte
    always @(posedge clock) begin
        if (dataLaneOe === 8'hFF && oeSeen === 1'b0) begin
            if (expQ.size() == 0) begin
                cmp(dataLaneOut, 8'hXX);
            end else begin
                cmp(dataLaneOut, expQ.pop_front());
            end
        end
        oeSeen <= (dataLaneOe === 8'hFF);
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        sarResult = 14'h0000;
        oeSeen = 1'b0;
        n_mismatch = 0;
        checked = 0;
        void'($urandom(32'hFD50));
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        host.pulse(1'b1, 1'b0);
        cmp({7'h00, trackHold}, 8'h00);
        cmp({7'h00, eocN}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            r = 14'($urandom);
            shut = i[1];
            bs = i[0];
            // Unread result, then a low-select third fall must start a fresh acquisition
            if (i == 5) begin
                sarResult <= ~r;
                host.acquire();
                host.convert(shut);
                repeat (CONV) @(posedge clock);
                cmp({7'h00, eocN}, 8'h00);
            end
            sarResult <= r;
            host.acquire();
            cmp({7'h00, trackHold}, 8'h01);
            cmp({7'h00, refPowered}, 8'h01);
            cmp({7'h00, corePowered}, 8'h01);
            cmp({7'h00, eocN}, 8'h01);
            cmp(dataLaneOe, 8'h00);
            host.convert(shut);
            cmp({7'h00, trackHold}, 8'h00);
            n = 16;
            while (eocN !== 1'b0 && n < CONV + 50) begin
                @(posedge clock);
                n++;
            end
            if (n >= CONV + 50) begin
                n_mismatch++;
                complete_run();
            end
            cmp({7'h00, n <= CONV + 1}, 8'h01);
            repeat (2) @(posedge clock);
            cmp({7'h00, refPowered}, {7'h00, ~shut});
            cmp({7'h00, corePowered}, 8'h00);
            cmp(dataLaneOe, 8'h00);
            expQ.push_back(bs ? {2'b00, r[13:8]} : r[7:0]);
            host.read(bs);
            cmp(dataLaneOe, 8'h00);
            if (i == 3) begin
                host.pulse(1'b1, bs);
                cmp({7'h00, trackHold}, 8'h00);
            end
        end
        // Reset in mid-acquisition; every output except dataLaneOut is checked back at its idle level
        host.acquire();
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        cmp({5'h00, trackHold, refPowered, corePowered}, 8'h00);
        cmp({7'h00, eocN}, 8'h01);
        cmp(dataLaneOe, 8'h00);
        host.pulse(1'b1, 1'b0);
        cmp({7'h00, trackHold}, 8'h00);
        repeat (4) @(posedge clock);
        cmp(8'(expQ.size()), 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
